// *** design/msp_params.svh ***
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH
`define MSP_AW 22
`define MSP_DW 32
`define MSP_EW 54
`define MSP_BCAST_LO 22'h380000
`define MSP_BCAST_HI 22'h3fffff
`define MSP_ID_MSB 21
`define MSP_ID_LSB 19
`define MSP_IOP_MSB 18
`define MSP_IOP_LSB 8
`define MSP_MEM_AW 8
`define MSP_MEM_WORDS 256
`define MSP_PIN_FIFO_DEPTH 4
`define MSP_DWB_DEPTH 2
`define MSP_SPORT_HOLD_MAX 4'h4
`define MSP_CHAIN_HOLD_MAX 4'h9
`define MSP_MEM_RD_WAIT 2'h1
`define MSP_IOP_RD_WAIT 2'h0
`define MSP_WS_FIRST_CYC 2'h2
`define MSP_RST_DATA 32'h00000000
`endif

// *** design/msp_pkg.sv ***
package msp_pkg;
   // ==========================================================
   // Read sequencer states, Gray coded along the usual path.
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_HOLD = 2'b01,
      RD_ACC = 2'b11,
      RD_DRIVE = 2'b10
   } msp_rd_state_type;
endpackage : msp_pkg

// *** design/msp_fifo.sv ***
`timescale 1ns/10ps
module msp_fifo #(
   parameter int W = 32,
   parameter int D = 32
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   assign in_ready = (cnt_q != CW'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= ptr_inc(wr_q);
         end
         if (pop) begin
            rd_q <= ptr_inc(rd_q);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : msp_fifo

// *** design/msp_slave_port.sv ***
// Summary of operation
// - Hold ACK low while write buffering full.
// - Six direct writes accepted before stalling.
// - Internal buffer held four or nine cycles.
// - Four-level pin FIFO, retires next cycle.
// - Pin FIFO invisible to local core.
// - Register writes finish within two cycles.
// - Reads wait while write data pending.
// - Pending flag while either buffer holds writes.
// - Register writes may overtake memory writes.
// - Read: latch address, ACK low, drive data.
// - One outstanding direct read at a time.
// - Writes one per cycle, reads slower.
// - Accept writes in broadcast region.
// - Broadcast-region read returns own memory.
// - Odd broadcast cycles: pull ACK if busy.
// - Even broadcast cycles: leave ACK undriven.
// - Broadcast one cycle, else three or more.
// - Wait state: ACK untouched first two cycles.
// - Two-deep shadow FIFO in front of memory.
`timescale 1ns/10ps
`include "msp_params.svh"
module msp_slave_port (
   // Clock and reset.
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Shared external bus.
   input wire logic [`MSP_AW-1:0] EXT_ADDR,
   input wire logic [`MSP_DW-1:0] EXT_DATA_I,
   output logic [`MSP_DW-1:0] EXT_DATA_O,
   output logic EXT_DATA_OE,
   input wire logic EXT_WR_N,
   input wire logic EXT_RD_N,
   input wire logic ACK_I,
   output logic ACK_O,
   output logic ACK_OE,
   output logic BUS_REQUEST_LINE_N,
   // Configuration and DMA activity.
   input wire logic [2:0] MP_ID,
   input wire logic MULTIPROC_WAIT_STATE_ENABLE,
   input wire logic SPORT_DMA_ALL_ACTIVE,
   input wire logic DMA_CHAIN_ACTIVE,
   // I/O processor register port.
   input wire logic IOP_BUSY,
   output logic IOP_WR_EN,
   output logic [`MSP_MEM_AW-1:0] IOP_WR_ADDR,
   output logic [`MSP_DW-1:0] IOP_WR_DATA,
   output logic IOP_RD_EN,
   output logic [`MSP_MEM_AW-1:0] IOP_RD_ADDR,
   input wire logic [`MSP_DW-1:0] IOP_RD_DATA,
   // Status.
   output logic DIRECT_WRITE_PENDING_FLAG
);
   // ==========================================================
   // Address decoding.
   function automatic logic in_bcast(input logic [`MSP_AW-1:0] a);
      in_bcast = (a >= `MSP_BCAST_LO) && (a <= `MSP_BCAST_HI);
   endfunction : in_bcast

   function automatic logic is_own(input logic [`MSP_AW-1:0] a, input logic [2:0] id);
      is_own = (a[`MSP_ID_MSB:`MSP_ID_LSB] == id) && !in_bcast(a);
   endfunction : is_own

   function automatic logic is_iop(input logic [`MSP_AW-1:0] a);
      is_iop = (a[`MSP_IOP_MSB:`MSP_IOP_LSB] == '0);
   endfunction : is_iop

   // ==========================================================
   // Internal memory with its shadow write FIFO.
   logic [`MSP_DW-1:0] mem_q [`MSP_MEM_WORDS];
   logic sh0_v_q;
   logic sh1_v_q;
   logic [`MSP_MEM_AW-1:0] sh0_a_q;
   logic [`MSP_MEM_AW-1:0] sh1_a_q;
   logic [`MSP_DW-1:0] sh0_d_q;
   logic [`MSP_DW-1:0] sh1_d_q;

   function automatic logic [`MSP_DW-1:0] mem_read(input logic [`MSP_MEM_AW-1:0] a);
      if (sh0_v_q && sh0_a_q == a) begin
         mem_read = sh0_d_q;
      end else if (sh1_v_q && sh1_a_q == a) begin
         mem_read = sh1_d_q;
      end else begin
         mem_read = mem_q[a];
      end
   endfunction : mem_read

   // ==========================================================
   // Bus decode.
   logic wr_act;
   logic rd_act;
   logic wr_own;
   logic bc_wr;
   logic rd_req;
   assign wr_act = !EXT_WR_N;
   assign rd_act = !EXT_RD_N;
   assign wr_own = wr_act && is_own(EXT_ADDR, MP_ID);
   assign bc_wr = wr_act && in_bcast(EXT_ADDR);
   assign rd_req = rd_act && (is_own(EXT_ADDR, MP_ID) || in_bcast(EXT_ADDR));

   // ==========================================================
   // Pin-level slave write FIFO and internal direct-write buffer.
   logic pin_in_valid;
   logic pin_in_ready;
   logic pin_out_valid;
   logic pin_out_ready;
   logic [`MSP_EW-1:0] pin_out_data;
   logic dwb_in_valid;
   logic dwb_in_ready;
   logic dwb_out_valid;
   logic dwb_out_ready;
   logic [`MSP_EW-1:0] dwb_out_data;
   logic head_iop;
   logic [`MSP_AW-1:0] head_addr;

   // Broadcast cycle tracking.
   logic [1:0] bc_cyc_q;
   logic bc_par_q;
   logic bc_taken_q;
   logic bc_samp;
   logic bc_done;
   assign bc_samp = !bc_par_q && (!MULTIPROC_WAIT_STATE_ENABLE || bc_cyc_q == `MSP_WS_FIRST_CYC);
   assign bc_done = bc_wr && bc_samp && ACK_I;

   assign pin_in_valid = (wr_own || (bc_wr && bc_samp && !bc_taken_q));

   // The pin FIFO has no port toward the local core.
   msp_fifo #(
      .W(`MSP_EW),
      .D(`MSP_PIN_FIFO_DEPTH)
   ) u_pin_fifo (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .in_valid(pin_in_valid),
      .in_ready(pin_in_ready),
      .in_data({EXT_ADDR, EXT_DATA_I}),
      .out_valid(pin_out_valid),
      .out_ready(pin_out_ready),
      .out_data(pin_out_data)
   );

   assign head_addr = pin_out_data[`MSP_EW-1:`MSP_DW];
   assign head_iop = is_iop(head_addr);
   // Register writes bypass the memory buffer and may overtake it.
   assign pin_out_ready = head_iop ? !IOP_BUSY : dwb_in_ready;
   assign dwb_in_valid = pin_out_valid && !head_iop;

   msp_fifo #(
      .W(`MSP_EW),
      .D(`MSP_DWB_DEPTH)
   ) u_dw_buf (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .in_valid(dwb_in_valid),
      .in_ready(dwb_in_ready),
      .in_data(pin_out_data),
      .out_valid(dwb_out_valid),
      .out_ready(dwb_out_ready),
      .out_data(dwb_out_data)
   );

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         bc_cyc_q <= 2'h0;
         bc_par_q <= 1'b0;
         bc_taken_q <= 1'b0;
      end else if (!bc_wr || bc_done) begin
         bc_cyc_q <= 2'h0;
         bc_par_q <= 1'b0;
         bc_taken_q <= 1'b0;
      end else begin
         if (bc_cyc_q != `MSP_WS_FIRST_CYC) begin
            bc_cyc_q <= bc_cyc_q + 2'h1;
         end
         if (!MULTIPROC_WAIT_STATE_ENABLE || bc_cyc_q == `MSP_WS_FIRST_CYC) begin
            bc_par_q <= !bc_par_q;
         end
         if (pin_in_valid && pin_in_ready) begin
            bc_taken_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Hold-off of the internal buffer by DMA activity.
   logic [3:0] hold_cnt_q;
   logic [3:0] hold_max;
   logic stall;
   assign hold_max = DMA_CHAIN_ACTIVE ? `MSP_CHAIN_HOLD_MAX : `MSP_SPORT_HOLD_MAX;
   assign stall = (SPORT_DMA_ALL_ACTIVE || DMA_CHAIN_ACTIVE) && hold_cnt_q < hold_max;
   assign dwb_out_ready = !stall;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         hold_cnt_q <= 4'h0;
      end else if (!SPORT_DMA_ALL_ACTIVE && !DMA_CHAIN_ACTIVE) begin
         hold_cnt_q <= 4'h0;
      end else if (stall) begin
         hold_cnt_q <= hold_cnt_q + 4'h1;
      end
   end

   // ==========================================================
   // Memory write retirement through the shadow FIFO.
   logic mem_wr;
   assign mem_wr = dwb_out_valid && dwb_out_ready;

   always_ff @(posedge CLK_SYS) begin
      if (mem_wr && sh1_v_q) begin
         mem_q[sh1_a_q] <= sh1_d_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sh0_v_q <= 1'b0;
         sh1_v_q <= 1'b0;
         sh0_a_q <= '0;
         sh1_a_q <= '0;
         sh0_d_q <= `MSP_RST_DATA;
         sh1_d_q <= `MSP_RST_DATA;
      end else if (mem_wr) begin
         sh1_v_q <= sh0_v_q;
         sh1_a_q <= sh0_a_q;
         sh1_d_q <= sh0_d_q;
         sh0_v_q <= 1'b1;
         sh0_a_q <= dwb_out_data[`MSP_DW+`MSP_MEM_AW-1:`MSP_DW];
         sh0_d_q <= dwb_out_data[`MSP_DW-1:0];
      end
   end

   // ==========================================================
   // Register write port.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         IOP_WR_EN <= 1'b0;
         IOP_WR_ADDR <= '0;
         IOP_WR_DATA <= `MSP_RST_DATA;
      end else begin
         IOP_WR_EN <= pin_out_valid && head_iop && !IOP_BUSY;
         if (pin_out_valid && head_iop && !IOP_BUSY) begin
            IOP_WR_ADDR <= head_addr[`MSP_MEM_AW-1:0];
            IOP_WR_DATA <= pin_out_data[`MSP_DW-1:0];
         end
      end
   end

   // ==========================================================
   // Direct read sequencer.
   msp_pkg::msp_rd_state_type rd_st_q;
   logic [`MSP_AW-1:0] rd_addr_q;
   logic [1:0] rd_cnt_q;
   logic wr_busy;
   assign wr_busy = pin_out_valid || dwb_out_valid || pin_in_valid;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         rd_st_q <= msp_pkg::RD_IDLE;
         rd_addr_q <= '0;
         rd_cnt_q <= 2'h0;
         IOP_RD_EN <= 1'b0;
         EXT_DATA_O <= `MSP_RST_DATA;
         EXT_DATA_OE <= 1'b0;
      end else begin
         IOP_RD_EN <= 1'b0;
         EXT_DATA_OE <= 1'b0;
         unique case (rd_st_q)
            msp_pkg::RD_IDLE: begin
               if (rd_req) begin
                  rd_addr_q <= EXT_ADDR;
                  rd_cnt_q <= is_iop(EXT_ADDR) ? `MSP_IOP_RD_WAIT : `MSP_MEM_RD_WAIT;
                  if (wr_busy) begin
                     rd_st_q <= msp_pkg::RD_HOLD;
                  end else begin
                     rd_st_q <= msp_pkg::RD_ACC;
                     IOP_RD_EN <= is_iop(EXT_ADDR);
                  end
               end
            end
            msp_pkg::RD_HOLD: begin
               if (!wr_busy) begin
                  rd_st_q <= msp_pkg::RD_ACC;
                  IOP_RD_EN <= is_iop(rd_addr_q);
               end
            end
            msp_pkg::RD_ACC: begin
               if (rd_cnt_q == 2'h0) begin
                  EXT_DATA_O <= is_iop(rd_addr_q) ? IOP_RD_DATA
                                : mem_read(rd_addr_q[`MSP_MEM_AW-1:0]);
                  EXT_DATA_OE <= 1'b1;
                  rd_st_q <= msp_pkg::RD_DRIVE;
               end else begin
                  rd_cnt_q <= rd_cnt_q - 2'h1;
               end
            end
            msp_pkg::RD_DRIVE: begin
               rd_st_q <= msp_pkg::RD_IDLE;
            end
         endcase
      end
   end

   assign IOP_RD_ADDR = rd_addr_q[`MSP_MEM_AW-1:0];

   // ==========================================================
   // Acknowledge, bus request and pending flag.
   always_comb begin
      ACK_O = 1'b0;
      ACK_OE = 1'b0;
      if (rd_req || rd_st_q != msp_pkg::RD_IDLE) begin
         ACK_OE = rd_act;
         ACK_O = (rd_st_q == msp_pkg::RD_DRIVE);
      end else if (wr_own) begin
         ACK_OE = 1'b1;
         ACK_O = pin_in_ready;
      end else if (bc_wr) begin
         ACK_OE = bc_samp && !pin_in_ready && !bc_taken_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         BUS_REQUEST_LINE_N <= 1'b1;
         DIRECT_WRITE_PENDING_FLAG <= 1'b0;
      end else begin
         BUS_REQUEST_LINE_N <= 1'b1;
         DIRECT_WRITE_PENDING_FLAG <= pin_out_valid || dwb_out_valid || pin_in_valid;
      end
   end
endmodule : msp_slave_port

// *** tb/msp_slave_port_properties.sv ***
`timescale 1ns/10ps
`include "msp_params.svh"
module msp_slave_port_checker (
   // Clock and reset.
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Bus and status.
   input wire logic [`MSP_AW-1:0] EXT_ADDR,
   input wire logic [`MSP_DW-1:0] EXT_DATA_I,
   input wire logic EXT_WR_N,
   input wire logic EXT_RD_N,
   input wire logic EXT_DATA_OE,
   input wire logic ACK_O,
   input wire logic ACK_OE,
   input wire logic BUS_REQUEST_LINE_N,
   input wire logic [2:0] MP_ID,
   input wire logic MULTIPROC_WAIT_STATE_ENABLE,
   input wire logic IOP_BUSY,
   input wire logic IOP_WR_EN,
   input wire logic [`MSP_DW-1:0] IOP_WR_DATA,
   input wire logic DIRECT_WRITE_PENDING_FLAG
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   logic bc;
   logic own;
   logic iop;
   logic wr_take;
   assign bc = EXT_ADDR >= `MSP_BCAST_LO;
   assign own = !bc && EXT_ADDR[`MSP_ID_MSB:`MSP_ID_LSB] == MP_ID;
   assign iop = EXT_ADDR[`MSP_IOP_MSB:`MSP_IOP_LSB] == '0;
   assign wr_take = !EXT_WR_N && own && ACK_OE && ACK_O;
   // ==========================================================
   // Properties.
   a_no_bus_req: assert property (BUS_REQUEST_LINE_N)
      else $error("Slave raised its bus request.");
   a_own_wr_answered: assert property (!EXT_WR_N && own |-> ACK_OE)
      else $error("Own write left without answer.");
   a_wr_sets_pending: assert property (wr_take |=> DIRECT_WRITE_PENDING_FLAG)
      else $error("Pending flag low after a write.");
   a_iop_wr_latency: assert property (wr_take && iop && !DIRECT_WRITE_PENDING_FLAG && !IOP_BUSY
      ##1 !IOP_BUSY |=> IOP_WR_EN && IOP_WR_DATA == $past(EXT_DATA_I, 2))
      else $error("Register write late or wrong.");
   a_read_opens_low: assert property ($fell(EXT_RD_N) && (own || bc) |-> ACK_OE && !ACK_O)
      else $error("Read did not hold the acknowledge low.");
   a_data_one_cycle: assert property (EXT_DATA_OE |=> !EXT_DATA_OE)
      else $error("Read data driven twice in a row.");
   a_ack_with_data: assert property (EXT_DATA_OE && !EXT_RD_N |-> ACK_OE && ACK_O)
      else $error("Read data without acknowledge.");
   a_read_after_drain: assert property (EXT_DATA_OE |-> !DIRECT_WRITE_PENDING_FLAG)
      else $error("Read served while writes pending.");
   a_bcast_pull_only: assert property (!EXT_WR_N && bc && ACK_OE |-> !ACK_O)
      else $error("Broadcast acknowledge driven high.");
   a_ws_quiet: assert property ($fell(EXT_WR_N) && bc && MULTIPROC_WAIT_STATE_ENABLE
      |-> !ACK_OE ##1 !ACK_OE)
      else $error("Acknowledge driven in wait-state cycles.");
   a_iop_read_time: assert property ($fell(EXT_RD_N) && own && iop && !DIRECT_WRITE_PENDING_FLAG
      |-> ##2 EXT_DATA_OE)
      else $error("Register read not answered on time.");
   c_wr_stall: cover property (!EXT_WR_N && own && ACK_OE && !ACK_O);
   c_read_data: cover property (EXT_DATA_OE);
   c_bcast_pull: cover property (!EXT_WR_N && bc && ACK_OE);
endmodule : msp_slave_port_checker
bind msp_slave_port msp_slave_port_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .EXT_ADDR(EXT_ADDR), .EXT_DATA_I(EXT_DATA_I), .EXT_WR_N(EXT_WR_N), .EXT_RD_N(EXT_RD_N),
   .EXT_DATA_OE(EXT_DATA_OE), .ACK_O(ACK_O), .ACK_OE(ACK_OE),
   .BUS_REQUEST_LINE_N(BUS_REQUEST_LINE_N), .MP_ID(MP_ID),
   .MULTIPROC_WAIT_STATE_ENABLE(MULTIPROC_WAIT_STATE_ENABLE), .IOP_BUSY(IOP_BUSY),
   .IOP_WR_EN(IOP_WR_EN), .IOP_WR_DATA(IOP_WR_DATA),
   .DIRECT_WRITE_PENDING_FLAG(DIRECT_WRITE_PENDING_FLAG));

// *** tb/msp_master_model.sv ***
`timescale 1ns/10ps
`include "msp_params.svh"
module msp_master_model (
   // Clock and wait-state option.
   input wire logic clk,
   input wire logic ws_en,
   // Bus as the master sees it.
   output logic [`MSP_AW-1:0] addr,
   output logic [`MSP_DW-1:0] wdata,
   output logic wr_n,
   output logic rd_n,
   input wire logic [`MSP_DW-1:0] rdata,
   input wire logic ack_o,
   input wire logic ack_oe,
   output logic ack_i
);
   // ==========================================================
   // Keeper and precharge hold the wire high unless a slave pulls it.
   assign ack_i = ack_oe ? ack_o : 1'b1;
   initial begin
      addr = '0;
      wdata = '0;
      wr_n = 1'b1;
      rd_n = 1'b1;
   end
   // Write held until taken; n counts the cycles it lasted.
   task automatic wr(input logic [`MSP_AW-1:0] a, input logic [`MSP_DW-1:0] d, output int n);
      logic b;
      b = a >= `MSP_BCAST_LO;
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_n = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (n < 40 && !(ack_i && (!b || (n[0] && (!ws_en || n > 2)))));
   endtask : wr
   // Released data lines show a changed pattern, never the old value.
   task automatic idle();
      @(negedge clk);
      wr_n = 1'b1;
      wdata = ~wdata;
   endtask : idle
   task automatic rd(input logic [`MSP_AW-1:0] a, output logic [`MSP_DW-1:0] d, output int n);
      @(negedge clk);
      addr = a;
      rd_n = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (n < 60 && !(ack_i && ack_oe));
      d = rdata;
      @(negedge clk);
      rd_n = 1'b1;
   endtask : rd
endmodule : msp_master_model

// *** tb/tb_multiproc_slave_access_port.sv ***
`timescale 1ns/10ps
`include "msp_params.svh"
module tb_multiproc_slave_access_port;
   localparam logic [21:0] MEM = 22'h100100;
   localparam logic [21:0] IOP = 22'h100000;
   localparam logic [21:0] BC = 22'h380100;
   logic clk, rst_n, wr_n, rd_n, ack_i, ack_o, ack_oe, data_oe, brq, ws, sport, chain;
   logic iop_wr, iop_rd, pend;
   logic [`MSP_AW-1:0] addr;
   logic [`MSP_DW-1:0] wdata, rdata, iop_wdata, iop_rdata;
   logic [`MSP_MEM_AW-1:0] iop_waddr, iop_raddr;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   assign iop_rdata = {24'h00c3a5, iop_raddr};
   msp_slave_port dut (.CLK_SYS(clk), .RST_N(rst_n), .EXT_ADDR(addr), .EXT_DATA_I(wdata),
      .EXT_DATA_O(rdata), .EXT_DATA_OE(data_oe), .EXT_WR_N(wr_n), .EXT_RD_N(rd_n),
      .ACK_I(ack_i), .ACK_O(ack_o), .ACK_OE(ack_oe), .BUS_REQUEST_LINE_N(brq),
      .MP_ID(3'h2), .MULTIPROC_WAIT_STATE_ENABLE(ws), .SPORT_DMA_ALL_ACTIVE(sport),
      .DMA_CHAIN_ACTIVE(chain), .IOP_BUSY(1'b0), .IOP_WR_EN(iop_wr), .IOP_WR_ADDR(iop_waddr),
      .IOP_WR_DATA(iop_wdata), .IOP_RD_EN(iop_rd), .IOP_RD_ADDR(iop_raddr),
      .IOP_RD_DATA(iop_rdata), .DIRECT_WRITE_PENDING_FLAG(pend));
   msp_master_model master (.clk(clk), .ws_en(ws), .addr(addr), .wdata(wdata), .wr_n(wr_n),
      .rd_n(rd_n), .rdata(rdata), .ack_o(ack_o), .ack_oe(ack_oe), .ack_i(ack_i));
   // ==========================================================
   // Checking and closing.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // Scenarios.
   task automatic t_mem();
      int n;
      logic [31:0] d;
      for (int i = 0; i < 3; i++) begin
         master.wr(MEM + 22'(i), 32'h10000a00 + 32'(i), n);
         chk("write cycles", 32'h1, 32'(n));
      end
      master.idle();
      chk("pending flag", 32'h1, 32'(pend));
      for (int i = 0; i < 3; i += 2) begin
         master.rd(MEM + 22'(i), d, n);
         chk("memory data", 32'h10000a00 + 32'(i), d);
      end
      master.rd(MEM + 22'h2, d, n);
      chk("memory read cycles", 32'h4, 32'(n));
      $display("t_mem done");
   endtask : t_mem
   task automatic t_iop();
      int n;
      logic [31:0] d;
      master.wr(IOP + 22'h33, 32'hbeef0033, n);
      master.idle();
      @(negedge clk);
      chk("register write strobe", 32'h1, 32'(iop_wr));
      chk("register write address", 32'h33, 32'(iop_waddr));
      chk("register write data", 32'hbeef0033, iop_wdata);
      master.rd(IOP + 22'h44, d, n);
      chk("register data", 32'h00c3a544, d);
      chk("register read cycles", 32'h3, 32'(n));
      $display("t_iop done");
   endtask : t_iop
   task automatic t_stall();
      int n;
      logic [31:0] d;
      @(negedge clk);
      chain = 1'b1;
      sport = 1'b1;
      for (int i = 0; i < 7; i++) begin
         master.wr(MEM + 22'h20 + 22'(i), 32'h77000000 + 32'(i), n);
         chk("stalled write", 32'h1, 32'(i < 6 ? n == 1 : n > 1 && n <= 12));
      end
      master.idle();
      chain = 1'b0;
      sport = 1'b0;
      master.rd(MEM + 22'h26, d, n);
      chk("data after stall", 32'h77000006, d);
      $display("t_stall done");
   endtask : t_stall
   task automatic t_bcast();
      int n;
      logic [31:0] d;
      master.wr(BC, 32'h5b000001, n);
      chk("broadcast ready", 32'h1, 32'(n));
      master.idle();
      master.rd(BC, d, n);
      chk("broadcast read", 32'h5b000001, d);
      chain = 1'b1;
      for (int i = 0; i < 6; i++) begin
         master.wr(MEM + 22'h40 + 22'(i), 32'(i), n);
      end
      master.wr(BC, 32'h5b000002, n);
      chk("broadcast busy", 32'h1, 32'(n >= 3 && n[0]));
      master.idle();
      chain = 1'b0;
      ws = 1'b1;
      master.wr(BC, 32'h5b000003, n);
      chk("broadcast wait state", 32'h3, 32'(n));
      master.idle();
      ws = 1'b0;
      master.rd(MEM, d, n);
      chk("own copy", 32'h5b000003, d);
      $display("t_bcast done");
   endtask : t_bcast
   // ==========================================================
   // Clock, reset, sequence and time limit.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      ws = 1'b0;
      sport = 1'b0;
      chain = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_mem();
      t_iop();
      t_stall();
      t_bcast();
      final_report();
   end
endmodule : tb_multiproc_slave_access_port
